//--- verilog/pgx_call_unit.sv
/*
 * program page select register, window address translation and the
 * far call / far return sequencer that saves and restores the page.
 * assumes memory and stack on the same clock, answering with mem_ack.
 */
`timescale 1ns/100ps
`default_nettype none

// How it works
// - page select held here; written by load/store port and by call/return
// - six-bit page picks one of 64 pages into the 16K window
// - addresses 0xc000 to 0xffff never use the page select value
// - vector fetches always translate unpaged, whatever the page is
// - call and return run atomically; interrupt hold is raised throughout
// - call saves old page in temp and loads new page in the same cycle
// - call computes return address and pushes it onto the stack
// - call then pushes the saved old page value
// - call ends with queue refill and jump to target in new page
// - non-indirect call takes its page from the command's immediate field
// - indirect call reads target and page through a memory pointer
// - return pops page and address, restores page, refills, resumes
// - call accepted from any address to any target
// - paged address is page bits 19:14 joined to cpu bits 13:0
module pgx_call_unit (
    input  wire logic              core_clk,     // core clock
    input  wire logic              rst,          // async reset, high
    input  wire logic [15:0]       acc_addr,     // cpu address to map
    input  wire logic              acc_vec,      // access is a vector fetch
    output logic      [19:0]       xl_addr,      // mapped address
    output logic                   xl_paged,     // mapped through window
    input  wire logic              pg_wr,        // load/store write of page
    input  wire logic [5:0]        pg_wdata,     // page write data
    output logic      [5:0]        page_sel,     // program_page_select
    input  wire logic              cmd_valid,    // call/return request
    input  wire pgx_pkg::pgx_cmd_t cmd,          // request fields
    output logic                   irq_hold,     // sequence busy, no irq
    output logic                   done,         // sequence finished
    output logic      [15:0]       jump_addr,    // where to resume
    output logic      [15:0]       sp_out,       // new stack pointer
    output pgx_pkg::pgx_mem_t      mem,          // memory request
    input  wire logic              mem_ack,      // memory access done
    input  wire logic [7:0]        mem_rdata     // memory read data
);

    // ==========================================================
    // address translation
    logic [19:0] xl_addr_reg;
    logic [19:0] xl_addr_next;
    logic        xl_paged_reg;
    logic        xl_paged_next;
    logic [5:0]  page_reg;
    logic        in_win;
    logic        fixed_area;

    always_comb begin
        in_win = (acc_addr >= pgx_pkg::WIN_BASE)
            && (acc_addr <= pgx_pkg::WIN_LAST);
        fixed_area = (acc_addr >= pgx_pkg::UNPAGED_BASE);
        xl_paged_next = in_win && !fixed_area && !acc_vec;
        if (xl_paged_next) begin
            xl_addr_next = {page_reg,
                acc_addr[pgx_pkg::OFS_W-1:0]};
        end else begin
            xl_addr_next = {pgx_pkg::EXT_PAD, acc_addr};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            xl_addr_reg  <= 20'h00000;
            xl_paged_reg <= 1'b0;
        end else begin
            xl_addr_reg  <= xl_addr_next;
            xl_paged_reg <= xl_paged_next;
        end
    end

    // ==========================================================
    // call / return sequencer
    pgx_pkg::pgx_state_t state_reg;
    pgx_pkg::pgx_state_t state_next;
    logic [5:0]          page_next;
    logic [5:0]          tmp_reg;
    logic [5:0]          tmp_next;
    logic [15:0]         tgt_reg;
    logic [15:0]         tgt_next;
    logic [15:0]         ret_reg;
    logic [15:0]         ret_next;
    logic [15:0]         ptr_reg;
    logic [15:0]         ptr_next;
    logic [15:0]         sp_reg;
    logic [15:0]         sp_next;
    logic                busy_reg;
    logic                busy_next;
    logic                done_reg;
    logic                done_next;
    logic [15:0]         jump_reg;
    logic [15:0]         jump_next;
    pgx_pkg::pgx_mem_t   mem_reg;
    pgx_pkg::pgx_mem_t   mem_next;

    always_comb begin
        state_next = state_reg;
        page_next  = page_reg;
        tmp_next   = tmp_reg;
        tgt_next   = tgt_reg;
        ret_next   = ret_reg;
        ptr_next   = ptr_reg;
        sp_next    = sp_reg;
        busy_next  = busy_reg;
        done_next  = 1'b0;
        jump_next  = jump_reg;
        mem_next   = mem_reg;
        case (state_reg)
            pgx_pkg::PGX_IDLE: begin
                if (pg_wr) begin
                    page_next = pg_wdata;
                end
                if (cmd_valid) begin
                    // no address check: any source, any target
                    busy_next = 1'b1;
                    ptr_next  = cmd.ptr;
                    sp_next   = cmd.sp;
                    tgt_next  = cmd.target;
                    ret_next  = cmd.pc + {13'h0000, cmd.len};
                    case (cmd.op)
                        pgx_pkg::PGX_CALL_IND: begin
                            mem_next   = '{1'b1, 1'b0, cmd.ptr,
                                8'h00};
                            state_next = pgx_pkg::PGX_FETCH_HI;
                        end
                        pgx_pkg::PGX_RET: begin
                            mem_next   = '{1'b1, 1'b0, cmd.sp,
                                8'h00};
                            state_next = pgx_pkg::PGX_POP_PG;
                        end
                        default: begin
                            tmp_next   = page_reg;
                            page_next  = cmd.page;
                            mem_next   = '{1'b1, 1'b1,
                                cmd.sp - pgx_pkg::OFS_ONE,
                                ret_next[7:0]};
                            state_next = pgx_pkg::PGX_PUSH_RLO;
                        end
                    endcase
                end
            end
            pgx_pkg::PGX_FETCH_HI: begin
                if (mem_ack) begin
                    tgt_next[15:8] = mem_rdata;
                    mem_next.addr  = ptr_reg + pgx_pkg::OFS_ONE;
                    state_next     = pgx_pkg::PGX_FETCH_LO;
                end
            end
            pgx_pkg::PGX_FETCH_LO: begin
                if (mem_ack) begin
                    tgt_next[7:0] = mem_rdata;
                    mem_next.addr = ptr_reg + pgx_pkg::OFS_TWO;
                    state_next    = pgx_pkg::PGX_FETCH_PG;
                end
            end
            pgx_pkg::PGX_FETCH_PG: begin
                if (mem_ack) begin
                    tmp_next   = page_reg;
                    page_next  = mem_rdata[5:0];
                    mem_next   = '{1'b1, 1'b1,
                        sp_reg - pgx_pkg::OFS_ONE, ret_reg[7:0]};
                    state_next = pgx_pkg::PGX_PUSH_RLO;
                end
            end
            pgx_pkg::PGX_PUSH_RLO: begin
                if (mem_ack) begin
                    mem_next.addr  = sp_reg - pgx_pkg::OFS_TWO;
                    mem_next.wdata = ret_reg[15:8];
                    state_next     = pgx_pkg::PGX_PUSH_RHI;
                end
            end
            pgx_pkg::PGX_PUSH_RHI: begin
                if (mem_ack) begin
                    mem_next.addr  = sp_reg - pgx_pkg::OFS_THR;
                    mem_next.wdata = {2'b00, tmp_reg};
                    state_next     = pgx_pkg::PGX_PUSH_PG;
                end
            end
            pgx_pkg::PGX_PUSH_PG: begin
                if (mem_ack) begin
                    mem_next.req = 1'b0;
                    sp_next      = sp_reg - pgx_pkg::OFS_THR;
                    jump_next    = tgt_reg;
                    done_next    = 1'b1;
                    busy_next    = 1'b0;
                    state_next   = pgx_pkg::PGX_IDLE;
                end
            end
            pgx_pkg::PGX_POP_PG: begin
                if (mem_ack) begin
                    page_next     = mem_rdata[5:0];
                    mem_next.addr = sp_reg + pgx_pkg::OFS_ONE;
                    state_next    = pgx_pkg::PGX_POP_HI;
                end
            end
            pgx_pkg::PGX_POP_HI: begin
                if (mem_ack) begin
                    ret_next[15:8] = mem_rdata;
                    mem_next.addr  = sp_reg + pgx_pkg::OFS_TWO;
                    state_next     = pgx_pkg::PGX_POP_LO;
                end
            end
            pgx_pkg::PGX_POP_LO: begin
                if (mem_ack) begin
                    mem_next.req = 1'b0;
                    sp_next      = sp_reg + pgx_pkg::OFS_THR;
                    jump_next    = {ret_reg[15:8], mem_rdata};
                    done_next    = 1'b1;
                    busy_next    = 1'b0;
                    state_next   = pgx_pkg::PGX_IDLE;
                end
            end
            default: begin
                mem_next   = '{1'b0, 1'b0, 16'h0000, 8'h00};
                busy_next  = 1'b0;
                state_next = pgx_pkg::PGX_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= pgx_pkg::PGX_IDLE;
            page_reg  <= pgx_pkg::PAGE_RST;
            tmp_reg   <= pgx_pkg::PAGE_RST;
            tgt_reg   <= 16'h0000;
            ret_reg   <= 16'h0000;
            ptr_reg   <= 16'h0000;
            sp_reg    <= 16'h0000;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
            jump_reg  <= 16'h0000;
            mem_reg   <= '{1'b0, 1'b0, 16'h0000, 8'h00};
        end else begin
            state_reg <= state_next;
            page_reg  <= page_next;
            tmp_reg   <= tmp_next;
            tgt_reg   <= tgt_next;
            ret_reg   <= ret_next;
            ptr_reg   <= ptr_next;
            sp_reg    <= sp_next;
            busy_reg  <= busy_next;
            done_reg  <= done_next;
            jump_reg  <= jump_next;
            mem_reg   <= mem_next;
        end
    end

    // ==========================================================
    // outputs
    assign xl_addr   = xl_addr_reg;
    assign xl_paged  = xl_paged_reg;
    assign page_sel  = page_reg;
    assign irq_hold  = busy_reg;
    assign done      = done_reg;
    assign jump_addr = jump_reg;
    assign sp_out    = sp_reg;
    assign mem       = mem_reg;

endmodule : pgx_call_unit

`default_nettype wire

//--- include/pgx_pkg.sv
/*
 * shared constants and types for the program page call/return unit.
 * assumes a 16-bit cpu address, byte-wide memory and a downward stack.
 */
package pgx_pkg;

    // ==========================================================
    // widths
    localparam int PAGE_W = 6;
    localparam int ADDR_W = 16;
    localparam int EXT_W  = 20;
    localparam int OFS_W  = 14;

    // ==========================================================
    // address map
    localparam logic [15:0] WIN_BASE     = 16'h8000;
    localparam logic [15:0] WIN_LAST     = 16'hbfff;
    localparam logic [15:0] UNPAGED_BASE = 16'hc000;
    localparam logic [3:0]  EXT_PAD      = 4'h0;

    // ==========================================================
    // reset values and stack frame offsets
    localparam logic [5:0]  PAGE_RST = 6'h00;
    localparam logic [15:0] OFS_ONE  = 16'h0001;
    localparam logic [15:0] OFS_TWO  = 16'h0002;
    localparam logic [15:0] OFS_THR  = 16'h0003;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        PGX_CALL_IMM = 2'b00,
        PGX_CALL_IND = 2'b01,
        PGX_RET      = 2'b10
    } pgx_op_t;

    typedef enum logic [3:0] {
        PGX_IDLE     = 4'b0000,
        PGX_FETCH_HI = 4'b0001,
        PGX_FETCH_LO = 4'b0010,
        PGX_FETCH_PG = 4'b0011,
        PGX_PUSH_RLO = 4'b0100,
        PGX_PUSH_RHI = 4'b0101,
        PGX_PUSH_PG  = 4'b0110,
        PGX_POP_PG   = 4'b0111,
        PGX_POP_HI   = 4'b1000,
        PGX_POP_LO   = 4'b1001
    } pgx_state_t;

    typedef struct packed {
        pgx_op_t     op;
        logic [5:0]  page;
        logic [15:0] target;
        logic [15:0] pc;
        logic [2:0]  len;
        logic [15:0] ptr;
        logic [15:0] sp;
    } pgx_cmd_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } pgx_mem_t;

endpackage : pgx_pkg

//--- testbench/pgx_call_unit_monitor.sv
/*
 * checker for the page call unit, bound to its ports.
 * assumes one clock domain and reset high.
 */
`timescale 1ns/100ps
`default_nettype none

// ===========================================
// checker
module pgx_call_unit_monitor (
    input wire logic              core_clk,  // core clock
    input wire logic              rst,       // async reset
    input wire logic [15:0]       acc_addr,  // cpu address
    input wire logic              acc_vec,   // vector fetch
    input wire logic [19:0]       xl_addr,   // mapped address
    input wire logic              xl_paged,  // window hit
    input wire logic [5:0]        page_sel,  // page select
    input wire logic              cmd_valid, // request
    input wire pgx_pkg::pgx_cmd_t cmd,       // request fields
    input wire logic              irq_hold,  // busy
    input wire logic              done,      // finished
    input wire logic [15:0]       sp_out,    // stack pointer
    input wire pgx_pkg::pgx_mem_t mem        // memory request
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    pgx_pkg::pgx_cmd_t cq_reg;
    pgx_pkg::pgx_cmd_t cq_next;
    logic [5:0]        pq_reg;
    logic [5:0]        pq_next;
    logic              take;
    logic [15:0]       ret;
    assign take = cmd_valid && !irq_hold;
    assign ret  = cq_reg.pc + {13'h0, cq_reg.len};
    // latch command and old page at take
    always_comb begin
        cq_next = take ? cmd : cq_reg;
        pq_next = take ? page_sel : pq_reg;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cq_reg <= '0;
            pq_reg <= '0;
        end else begin
            cq_reg <= cq_next;
            pq_reg <= pq_next;
        end
    end

    chk_win_map:
    assert property (acc_addr inside {[16'h8000:16'hbfff]} && !acc_vec |=>
        xl_paged && xl_addr == {$past(page_sel), $past(acc_addr[13:0])})
        else $error("window mapping wrong");
    chk_unpaged_map:
    assert property (acc_vec || acc_addr < 16'h8000 || acc_addr >= 16'hc000
        |=> !xl_paged && xl_addr == {4'h0, $past(acc_addr)})
        else $error("unpaged mapping wrong");
    chk_hold_take:
    assert property (take |=> irq_hold) else $error("hold not raised");
    chk_hold_end:
    assert property ($fell(irq_hold) |-> done) else $error("hold fell early");
    chk_page_load:
    assert property (take && cmd.op == pgx_pkg::PGX_CALL_IMM |=>
        page_sel == cq_reg.page) else $error("page not loaded");
    chk_ret_push:
    assert property (take && cmd.op == pgx_pkg::PGX_CALL_IMM |=> mem.req &&
        mem.we && mem.addr == cq_reg.sp - 16'h1 && mem.wdata == ret[7:0])
        else $error("return push wrong");
    chk_page_push:
    assert property (mem.req && mem.we && mem.addr == cq_reg.sp - 16'h3 |->
        mem.wdata == {2'b00, pq_reg}) else $error("old page push wrong");
    chk_ind_ptr:
    assert property (take && cmd.op == pgx_pkg::PGX_CALL_IND |=> mem.req &&
        !mem.we && mem.addr == cq_reg.ptr) else $error("pointer read wrong");
    chk_done_sp:
    assert property (done |-> sp_out == (cq_reg.op == pgx_pkg::PGX_RET ?
        cq_reg.sp + 16'h3 : cq_reg.sp - 16'h3)) else $error("stack ptr wrong");
    cover property (done && cq_reg.op == pgx_pkg::PGX_CALL_IMM);
    cover property (done && cq_reg.op == pgx_pkg::PGX_CALL_IND);
    cover property (done && cq_reg.op == pgx_pkg::PGX_RET);
endmodule : pgx_call_unit_monitor

bind pgx_call_unit pgx_call_unit_monitor mon_u (
    .core_clk(core_clk), .rst(rst), .acc_addr(acc_addr), .acc_vec(acc_vec),
    .xl_addr(xl_addr), .xl_paged(xl_paged), .page_sel(page_sel),
    .cmd_valid(cmd_valid), .cmd(cmd), .irq_hold(irq_hold), .done(done),
    .sp_out(sp_out), .mem(mem)
);
`default_nettype wire

//--- testbench/pgx_mem_model.sv
/*
 * byte memory and stack answering the unit's requests.
 * assumes slow gives wait cycles before each ack.
 */
`timescale 1ns/100ps
`default_nettype none

// ===========================================
// memory model
module pgx_mem_model (
    input  wire logic              core_clk,  // core clock
    input  wire pgx_pkg::pgx_mem_t mem,       // request
    input  wire logic [1:0]        slow,      // wait cycles
    output logic                   mem_ack,   // access done
    output logic      [7:0]        mem_rdata  // read byte
);
    logic [7:0] m [0:65535];
    logic [1:0] wait_reg;
    assign mem_ack   = mem.req && wait_reg == slow;
    // data invalid outside the ack cycle
    assign mem_rdata = mem_ack ? m[mem.addr] : ~m[mem.addr];
    always @(posedge core_clk) begin
        if (mem_ack && mem.we) begin
            m[mem.addr] <= mem.wdata;
        end
        wait_reg <= (mem_ack || !mem.req) ? 2'h0 : wait_reg + 2'h1;
    end
endmodule : pgx_mem_model
`default_nettype wire

//--- testbench/program_page_call_return_bench.sv
/*
 * self-checking bench for the page call unit.
 * assumes the memory model and the bound checker.
 */
`timescale 1ns/100ps
`default_nettype none

// ===========================================
// bench
module program_page_call_return_bench;
    logic              core_clk, rst, acc_vec, xl_paged, pg_wr;
    logic              cmd_valid, irq_hold, done, mem_ack;
    logic [15:0]       acc_addr, jump_addr, sp_out;
    logic [19:0]       xl_addr;
    logic [5:0]        pg_wdata, page_sel;
    logic [7:0]        mem_rdata;
    logic [1:0]        slow;
    pgx_pkg::pgx_cmd_t cmd;
    pgx_pkg::pgx_mem_t mem;
    int                errors = 0;
    int                num_checks = 0;
    int                cyc = 0;

    pgx_call_unit dut_u (.core_clk(core_clk), .rst(rst), .acc_addr(acc_addr),
        .acc_vec(acc_vec), .xl_addr(xl_addr), .xl_paged(xl_paged),
        .pg_wr(pg_wr), .pg_wdata(pg_wdata), .page_sel(page_sel),
        .cmd_valid(cmd_valid), .cmd(cmd), .irq_hold(irq_hold), .done(done),
        .jump_addr(jump_addr), .sp_out(sp_out), .mem(mem),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    pgx_mem_model mem_u (.core_clk(core_clk), .mem(mem), .slow(slow),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic t_map;
        logic [15:0] a [6] = '{16'h8123, 16'hbfff, 16'h8000, 16'hc000,
                               16'h7fff, 16'h9abc};
        logic [5:0]  v = 6'b100000;
        logic        hit;
        chk(page_sel, 20'h0);
        @(posedge core_clk);
        pg_wr <= 1'b1;
        pg_wdata <= 6'h2a;
        @(posedge core_clk);
        pg_wr <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            acc_addr <= a[i];
            acc_vec <= v[i];
            @(posedge core_clk);
            #1;
            hit = a[i][15:14] == 2'b10 && !v[i];
            chk(xl_addr, hit ? {6'h2a, a[i][13:0]} : {4'h0, a[i]});
            chk(xl_paged, hit);
        end
        $display("test map end");
    endtask : t_map

    // run one sequence, a page write is tried while busy
    task automatic go(input pgx_pkg::pgx_cmd_t c, input logic [1:0] s,
        input logic [5:0] pg, input logic [15:0] ja, input logic [15:0] sp);
        int n;
        @(posedge core_clk);
        slow <= s;
        cmd <= c;
        cmd_valid <= 1'b1;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        pg_wr <= 1'b1;
        pg_wdata <= 6'h3f;
        @(posedge core_clk);
        pg_wr <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(n < 40, 20'h1);
        chk(page_sel, pg);
        chk(jump_addr, ja);
        chk(sp_out, sp);
    endtask : go

    task automatic t_call_imm;
        go('{pgx_pkg::PGX_CALL_IMM, 6'h15, 16'h8400, 16'hc010, 3'h4, 16'h0,
            16'h0900}, 2'h0, 6'h15, 16'h8400, 16'h08fd);
        chk(mem_u.m[16'h08ff], 20'h14);
        chk(mem_u.m[16'h08fe], 20'hc0);
        chk(mem_u.m[16'h08fd], 20'h2a);
        $display("test call imm end");
    endtask : t_call_imm

    task automatic t_call_ind;
        mem_u.m[16'h1000] = 8'h90;
        mem_u.m[16'h1001] = 8'h20;
        mem_u.m[16'h1002] = 8'h07;
        go('{pgx_pkg::PGX_CALL_IND, 6'h00, 16'h0, 16'h8400, 3'h3, 16'h1000,
            16'h08fd}, 2'h2, 6'h07, 16'h9020, 16'h08fa);
        chk(mem_u.m[16'h08fc], 20'h03);
        chk(mem_u.m[16'h08fb], 20'h84);
        chk(mem_u.m[16'h08fa], 20'h15);
        $display("test call ind end");
    endtask : t_call_ind

    task automatic t_ret;
        go('{pgx_pkg::PGX_RET, 6'h0, 16'h0, 16'h0, 3'h0, 16'h0, 16'h08fa},
            2'h1, 6'h15, 16'h8403, 16'h08fd);
        go('{pgx_pkg::PGX_RET, 6'h0, 16'h0, 16'h0, 3'h0, 16'h0, 16'h08fd},
            2'h0, 6'h2a, 16'hc014, 16'h0900);
        $display("test return end");
    endtask : t_ret

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors = errors + 1;
            complete_run();
        end
    end

    initial begin
        rst = 1'b1;
        acc_addr = 16'h0;
        acc_vec = 1'b0;
        pg_wr = 1'b0;
        pg_wdata = 6'h0;
        cmd_valid = 1'b0;
        cmd = '0;
        slow = 2'h0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_map();
        t_call_imm();
        t_call_ind();
        t_ret();
        complete_run();
    end
endmodule : program_page_call_return_bench
`default_nettype wire
